// [sfds_top.sv]
// two-channel bit-oriented transmit framer with dma requests, receive status and vectoring
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module sfds_top (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [1:0]  cts_n,
   input  wire logic [1:0]  tx_bit_tick,
   output logic      [1:0]  txd,
   input  wire logic [1:0]  rx_overrun_pulse,
   input  wire logic [1:0]  rx_eof_pulse,
   input  wire logic [1:0]  rx_crc_err,
   input  wire logic [5:0]  rx_residue,
   input  wire logic        hold_acknowledge_in_n,
   input  wire logic        dma_rd_n,
   input  wire logic        dma_wr_n,
   input  wire logic [7:0]  dma_wdata,
   output logic             tx_dma_request_first_chan,
   output logic             tx_dma_request_second_chan,
   output logic             int_n
);
   logic [7:0]        ctrl_q [2];
   logic [7:0]        vbase_q;
   sfds_pkg::sfds_tx_t tx_st_q [2];
   logic [15:0]       shreg_q [2];
   logic [4:0]        bitcnt_q [2];
   logic [2:0]        ones_q [2];
   logic [15:0]       crc_q [2];
   logic [7:0]        tbuf_q [2];
   logic [1:0]        buf_full_q, eom_q, ext_q, req_q, inh_q, cts_n_q;
   logic [1:0]        ovr_q, eof_q, crcerr_q;
   logic [2:0]        res_q [2];
   logic [1:0]        int_req, bufwr, cmd_abort, cmd_rext, cmd_rtxp, cmd_err, spec;
   logic [7:0]        bufwr_data [2];
   logic              ap_wr_q, ap_rd_q, rd_n_q, wr_n_q, accept, dma_wr_fire;
   logic [7:0]        ap_addr_q;
   logic [2:0]        vcode;
   logic [7:0]        vstat;
   logic [31:0]       rdata_q;
   logic              int_n_q;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? sfds_pkg::CRC_POLY : 16'h0000);
   endfunction : crc_step

   function automatic logic [7:0] reg_ofs(input logic ch, input logic [7:0] ofs);
      reg_ofs = ch ? ofs + sfds_pkg::CH_STRIDE : ofs;
   endfunction : reg_ofs

   // ahb-lite slave, zero wait states, read data snapshot at the address phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ap_wr_q   <= 1'b0;
         ap_rd_q   <= 1'b0;
         ap_addr_q <= 8'h00;
      end else if (hready) begin
         ap_wr_q   <= hsel & htrans[1] & hwrite;
         ap_rd_q   <= hsel & htrans[1] & ~hwrite;
         ap_addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         rdata_q <= 32'h00000000;
         for (int c = 0; c < 2; c++) begin
            if (haddr[7:0] == reg_ofs(c[0], sfds_pkg::OFS_CTRL))
               rdata_q[7:0] <= ctrl_q[c];
            if (haddr[7:0] == reg_ofs(c[0], sfds_pkg::OFS_STATUS)) begin
               rdata_q[sfds_pkg::ST_BEMPTY] <= ~buf_full_q[c];
               rdata_q[sfds_pkg::ST_EOM]    <= eom_q[c];
               rdata_q[sfds_pkg::ST_CTS]    <= ~cts_n[c];
               rdata_q[sfds_pkg::ST_EXT]    <= ext_q[c];
               rdata_q[sfds_pkg::ST_OVR]    <= ovr_q[c];
               rdata_q[sfds_pkg::ST_EOF]    <= eof_q[c];
               rdata_q[sfds_pkg::ST_CRCERR] <= crcerr_q[c];
               rdata_q[sfds_pkg::ST_RES +: 3] <= res_q[c];
               rdata_q[sfds_pkg::ST_REQ]    <= req_q[c];
               rdata_q[sfds_pkg::ST_INH]    <= inh_q[c];
            end
         end
         if (haddr[7:0] == sfds_pkg::OFS_VBASE)
            rdata_q[7:0] <= vbase_q;
         if (haddr[7:0] == sfds_pkg::OFS_VSTAT)
            rdata_q[7:0] <= vstat;
      end
   end

   // write decode in the data phase; commands are one-cycle strobes
   always_comb begin
      accept      = hold_acknowledge_in_n | (rd_n_q & ~dma_rd_n) | (wr_n_q & ~dma_wr_n);
      dma_wr_fire = ~hold_acknowledge_in_n & wr_n_q & ~dma_wr_n;
      for (int c = 0; c < 2; c++) begin
         cmd_abort[c] = ap_wr_q && ap_addr_q == reg_ofs(c[0], sfds_pkg::OFS_CMD)
                        && hwdata[2:0] == sfds_pkg::CMD_ABORT;
         cmd_rext[c]  = ap_wr_q && ap_addr_q == reg_ofs(c[0], sfds_pkg::OFS_CMD)
                        && hwdata[2:0] == sfds_pkg::CMD_RST_EXT;
         cmd_rtxp[c]  = ap_wr_q && ap_addr_q == reg_ofs(c[0], sfds_pkg::OFS_CMD)
                        && hwdata[2:0] == sfds_pkg::CMD_RST_TXP;
         cmd_err[c]   = ap_wr_q && ap_addr_q == reg_ofs(c[0], sfds_pkg::OFS_CMD)
                        && hwdata[2:0] == sfds_pkg::CMD_ERR_RST;
         bufwr[c]      = ap_wr_q && ap_addr_q == reg_ofs(c[0], sfds_pkg::OFS_TXDATA);
         bufwr_data[c] = hwdata[7:0];
         int_req[c]    = ctrl_q[c][sfds_pkg::CTRL_DMA] && tx_st_q[c] != sfds_pkg::TX_OFF
                         && !buf_full_q[c] && !inh_q[c];
         spec[c]       = (ovr_q[c] | eof_q[c])
                         && ctrl_q[c][sfds_pkg::CTRL_RXM +: 2] != 2'b00;
      end
      // the dma write goes to the highest-priority channel in service
      if (dma_wr_fire && req_q[0]) begin
         bufwr[0]      = 1'b1;
         bufwr_data[0] = dma_wdata;
      end else if (dma_wr_fire && req_q[1]) begin
         bufwr[1]      = 1'b1;
         bufwr_data[1] = dma_wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q[0] <= sfds_pkg::CTRL_RST;
         ctrl_q[1] <= sfds_pkg::CTRL_RST;
         vbase_q   <= sfds_pkg::VBASE_RST;
      end else if (ap_wr_q) begin
         if (ap_addr_q == sfds_pkg::OFS_CTRL)
            ctrl_q[0] <= hwdata[7:0] & sfds_pkg::CTRL_MASK_A;
         if (ap_addr_q == reg_ofs(1'b1, sfds_pkg::OFS_CTRL))
            ctrl_q[1] <= hwdata[7:0];
         if (ap_addr_q == sfds_pkg::OFS_VBASE)
            vbase_q <= hwdata[7:0];
      end
   end

   // dma request register; a buffer write wins over a new acceptance
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q  <= 2'b00;
         inh_q  <= 2'b00;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end else begin
         rd_n_q <= dma_rd_n;
         wr_n_q <= dma_wr_n;
         for (int c = 0; c < 2; c++) begin
            if (bufwr[c] || cmd_rtxp[c] || !int_req[c])
               req_q[c] <= 1'b0;
            else if (accept)
               req_q[c] <= 1'b1;
            if (bufwr[c])
               inh_q[c] <= 1'b0;
            else if (cmd_rtxp[c])
               inh_q[c] <= 1'b1;
         end
      end
   end
   assign tx_dma_request_first_chan  = req_q[0];
   assign tx_dma_request_second_chan = req_q[1];

   // transmitter: flags in idle, data, closing crc, closing flag, abort
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < 2; c++) begin
            tx_st_q[c]  <= sfds_pkg::TX_OFF;
            shreg_q[c]  <= sfds_pkg::ABORT_CHAR;
            bitcnt_q[c] <= 5'd0;
            ones_q[c]   <= 3'd0;
            crc_q[c]    <= sfds_pkg::CRC_INIT;
            tbuf_q[c]   <= 8'h00;
         end
         buf_full_q <= 2'b00;
         eom_q      <= 2'b00;
         txd        <= 2'b11;
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic        b;
            logic [15:0] cnx;
            b   = shreg_q[c][0];
            cnx = crc_step(crc_q[c], b);
            if (bufwr[c]) begin
               tbuf_q[c]     <= bufwr_data[c];
               buf_full_q[c] <= 1'b1;
               eom_q[c]      <= 1'b0;
            end
            if (!ctrl_q[c][sfds_pkg::CTRL_TXEN]) begin
               tx_st_q[c] <= sfds_pkg::TX_OFF;
               txd[c]     <= 1'b1;
            end else if (cmd_abort[c]) begin
               // the stuffing run before it makes the total 8 to 13 ones
               tx_st_q[c]    <= sfds_pkg::TX_ABORT;
               shreg_q[c]    <= sfds_pkg::ABORT_CHAR;
               bitcnt_q[c]   <= sfds_pkg::ABORT_BITS;
               buf_full_q[c] <= 1'b0;
               ones_q[c]     <= 3'd0;
            end else if (tx_bit_tick[c]) begin
               if (tx_st_q[c] == sfds_pkg::TX_OFF) begin
                  tx_st_q[c]  <= sfds_pkg::TX_IDLE;
                  shreg_q[c]  <= sfds_pkg::FLAG_CHAR;
                  bitcnt_q[c] <= sfds_pkg::BYTE_BITS;
               end else if ((tx_st_q[c] == sfds_pkg::TX_DATA || tx_st_q[c] == sfds_pkg::TX_CRC)
                            && ones_q[c] == sfds_pkg::STUFF_RUN) begin
                  txd[c]    <= 1'b0;
                  ones_q[c] <= 3'd0;
               end else begin
                  txd[c]     <= b;
                  shreg_q[c] <= {1'b0, shreg_q[c][15:1]};
                  if ((tx_st_q[c] == sfds_pkg::TX_DATA || tx_st_q[c] == sfds_pkg::TX_CRC) && b)
                     ones_q[c] <= ones_q[c] + 3'd1;
                  else
                     ones_q[c] <= 3'd0;
                  if (tx_st_q[c] == sfds_pkg::TX_DATA)
                     crc_q[c] <= cnx;
                  bitcnt_q[c] <= bitcnt_q[c] - 5'd1;
                  if (bitcnt_q[c] == 5'd1) begin
                     bitcnt_q[c] <= sfds_pkg::BYTE_BITS;
                     case (tx_st_q[c])
                        sfds_pkg::TX_IDLE, sfds_pkg::TX_CLOSE: begin
                           if (buf_full_q[c] && !bufwr[c]) begin
                              tx_st_q[c]    <= sfds_pkg::TX_DATA;
                              shreg_q[c]    <= {8'h00, tbuf_q[c]};
                              buf_full_q[c] <= 1'b0;
                              crc_q[c]      <= sfds_pkg::CRC_INIT;
                           end else begin
                              tx_st_q[c] <= sfds_pkg::TX_IDLE;
                              shreg_q[c] <= sfds_pkg::FLAG_CHAR;
                           end
                        end
                        sfds_pkg::TX_DATA: begin
                           if (buf_full_q[c] && !bufwr[c]) begin
                              shreg_q[c]    <= {8'h00, tbuf_q[c]};
                              buf_full_q[c] <= 1'b0;
                           end else begin
                              // underrun or end of message closes the frame
                              tx_st_q[c]  <= sfds_pkg::TX_CRC;
                              shreg_q[c]  <= ~cnx;
                              bitcnt_q[c] <= sfds_pkg::CRC_BITS;
                              eom_q[c]    <= 1'b1;
                           end
                        end
                        sfds_pkg::TX_CRC: begin
                           tx_st_q[c] <= sfds_pkg::TX_CLOSE;
                           shreg_q[c] <= sfds_pkg::FLAG_CHAR;
                        end
                        sfds_pkg::TX_ABORT: begin
                           tx_st_q[c] <= sfds_pkg::TX_IDLE;
                           shreg_q[c] <= sfds_pkg::FLAG_CHAR;
                        end
                        default: begin
                           tx_st_q[c] <= sfds_pkg::TX_IDLE;
                           shreg_q[c] <= sfds_pkg::FLAG_CHAR;
                        end
                     endcase
                  end
               end
            end
         end
      end
   end

   // external status latch: cts going active, entry into the closing crc
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_q   <= 2'b00;
         cts_n_q <= 2'b11;
      end else begin
         cts_n_q <= cts_n;
         for (int c = 0; c < 2; c++) begin
            if ((cts_n_q[c] && !cts_n[c]))
               ext_q[c] <= 1'b1;
            else if (tx_st_q[c] == sfds_pkg::TX_DATA && eom_q[c] == 1'b0
                     && bitcnt_q[c] == 5'd1 && tx_bit_tick[c] && ones_q[c] != sfds_pkg::STUFF_RUN
                     && !(buf_full_q[c] && !bufwr[c]) && ctrl_q[c][sfds_pkg::CTRL_TXEN]
                     && !cmd_abort[c])
               ext_q[c] <= 1'b1;
            else if (cmd_rext[c])
               ext_q[c] <= 1'b0;
         end
      end
   end

   // special receive status; set wins over the error reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ovr_q    <= 2'b00;
         eof_q    <= 2'b00;
         crcerr_q <= 2'b00;
         res_q[0] <= 3'd0;
         res_q[1] <= 3'd0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (rx_overrun_pulse[c])
               ovr_q[c] <= 1'b1;
            else if (cmd_err[c])
               ovr_q[c] <= 1'b0;
            if (rx_eof_pulse[c]) begin
               eof_q[c]    <= 1'b1;
               crcerr_q[c] <= rx_crc_err[c];
               res_q[c]    <= rx_residue[3*c +: 3];
            end else if (cmd_err[c]) begin
               eof_q[c]    <= 1'b0;
               crcerr_q[c] <= 1'b0;
            end
         end
      end
   end

   // fixed priority: a special, a external, b special, b external
   always_comb begin
      if (spec[0])
         vcode = sfds_pkg::VEC_A_SPEC;
      else if (ext_q[0] && ctrl_q[0][sfds_pkg::CTRL_EXTIE])
         vcode = sfds_pkg::VEC_A_EXT;
      else if (spec[1])
         vcode = sfds_pkg::VEC_B_SPEC;
      else if (ext_q[1] && ctrl_q[1][sfds_pkg::CTRL_EXTIE])
         vcode = sfds_pkg::VEC_B_EXT;
      else
         vcode = sfds_pkg::VEC_NONE;
      vstat = vbase_q;
      if (ctrl_q[1][sfds_pkg::CTRL_SAV]) begin
         if (ctrl_q[1][sfds_pkg::CTRL_M86])
            vstat[2:0] = vcode;
         else
            vstat[4:2] = vcode;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         int_n_q <= 1'b1;
      else
         int_n_q <= ~(|(ext_q & {ctrl_q[1][sfds_pkg::CTRL_EXTIE],
                                ctrl_q[0][sfds_pkg::CTRL_EXTIE]}) | (|spec));
   end
   assign int_n = int_n_q;

   AST_CTS_EXT: assert property (@(posedge clk) disable iff (!nrst)
      (cts_n_q[0] && !cts_n[0]) |=> ext_q[0]) else $error("cts edge did not set ext latch");
   AST_EOM_CRC: assert property (@(posedge clk) disable iff (!nrst)
      $rose(eom_q[0]) |-> tx_st_q[0] == sfds_pkg::TX_CRC && bitcnt_q[0] == 5'd16 && ext_q[0])
      else $error("closing crc not started with ext latch");
   AST_INT_LOW: assert property (@(posedge clk) disable iff (!nrst)
      (ext_q[0] && ctrl_q[0][1]) [*2] |-> !int_n) else $error("interrupt not driven low");
   AST_ABORT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_abort[0] && ctrl_q[0][0]) |=> tx_st_q[0] == sfds_pkg::TX_ABORT && !buf_full_q[0])
      else $error("abort did not discard");
   AST_ABORT_ONES: assert property (@(posedge clk) disable iff (!nrst)
      (tx_st_q[0] == sfds_pkg::TX_ABORT && tx_bit_tick[0] && ctrl_q[0][0] && !cmd_abort[0])
      |=> txd[0])
      else $error("abort bit not one");
   AST_WR_CLR: assert property (@(posedge clk) disable iff (!nrst)
      bufwr[0] |=> !req_q[0]) else $error("buffer write left request");
   AST_INHIBIT: assert property (@(posedge clk) disable iff (!nrst)
      inh_q[0] |-> !req_q[0]) else $error("request while inhibited");
   AST_HAI_EDGE: assert property (@(posedge clk) disable iff (!nrst)
      (!hold_acknowledge_in_n && !accept && !req_q[1]) |=> !req_q[1])
      else $error("request accepted without strobe edge");
   AST_PRIO: assert property (@(posedge clk) disable iff (!nrst)
      (dma_wr_fire && req_q == 2'b11) |=> buf_full_q[0] && !$past(bufwr[1]))
      else $error("channel b served before a");
   AST_STUFF: assert property (@(posedge clk) disable iff (!nrst)
      (tx_st_q[0] == sfds_pkg::TX_DATA && ones_q[0] == 3'd5 && tx_bit_tick[0]
       && ctrl_q[0][0] && !cmd_abort[0]) |=> !txd[0] && ones_q[0] == 3'd0)
      else $error("no zero after five ones");
   AST_SPEC_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      (ovr_q[0] && !cmd_err[0]) |=> ovr_q[0]) else $error("overrun lost before error reset");
   AST_EOF_VALID: assert property (@(posedge clk) disable iff (!nrst)
      rx_eof_pulse[0] |=> eof_q[0] && crcerr_q[0] == $past(rx_crc_err[0]))
      else $error("end of frame status wrong");
   AST_VEC: assert property (@(posedge clk) disable iff (!nrst)
      (ctrl_q[1][2] && ctrl_q[1][6] && !spec[0] && !(ext_q[0] && ctrl_q[0][1]) && spec[1])
      |-> vstat[2:0] == 3'b011) else $error("vector code wrong");

   COV_EOM: cover property (@(posedge clk) disable iff (!nrst) $rose(eom_q[0]));
   COV_RESTART: cover property (@(posedge clk) disable iff (!nrst)
      tx_st_q[0] == sfds_pkg::TX_CLOSE ##1 tx_st_q[0] == sfds_pkg::TX_DATA);
   COV_ABORT: cover property (@(posedge clk) disable iff (!nrst)
      tx_st_q[0] == sfds_pkg::TX_ABORT);
   COV_BOTH_REQ: cover property (@(posedge clk) disable iff (!nrst) req_q == 2'b11);
endmodule : sfds_top

// [sfds_pkg.sv]
// constants, register map and types for the frame dma service block
package sfds_pkg;
   // register map, channel A at 0x00, channel B at 0x10
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMD     = 8'h04;
   localparam logic [7:0] OFS_TXDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0c;
   localparam logic [7:0] CH_STRIDE   = 8'h10;
   localparam logic [7:0] OFS_VBASE   = 8'h20;
   localparam logic [7:0] OFS_VSTAT   = 8'h24;
   // control register fields
   localparam int         CTRL_TXEN   = 0;
   localparam int         CTRL_EXTIE  = 1;
   localparam int         CTRL_SAV    = 2;
   localparam int         CTRL_RXM    = 3;
   localparam int         CTRL_DMA    = 5;
   localparam int         CTRL_M86    = 6;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] CTRL_MASK_A = 8'hfb;
   // command codes in bits 2:0 of the command register
   localparam logic [2:0] CMD_ABORT   = 3'h1;
   localparam logic [2:0] CMD_RST_EXT = 3'h2;
   localparam logic [2:0] CMD_RST_TXP = 3'h3;
   localparam logic [2:0] CMD_ERR_RST = 3'h4;
   // status register fields
   localparam int         ST_BEMPTY   = 0;
   localparam int         ST_EOM      = 1;
   localparam int         ST_CTS      = 2;
   localparam int         ST_EXT      = 3;
   localparam int         ST_OVR      = 4;
   localparam int         ST_EOF      = 5;
   localparam int         ST_CRCERR   = 6;
   localparam int         ST_RES      = 7;
   localparam int         ST_REQ      = 10;
   localparam int         ST_INH      = 11;
   // serial framing
   localparam logic [15:0] FLAG_CHAR  = 16'h007e;
   localparam logic [15:0] ABORT_CHAR = 16'hffff;
   localparam logic [4:0]  BYTE_BITS  = 5'd8;
   localparam logic [4:0]  CRC_BITS   = 5'd16;
   localparam logic [4:0]  ABORT_BITS = 5'd8;
   localparam logic [2:0]  STUFF_RUN  = 3'd5;
   localparam logic [15:0] CRC_INIT   = 16'hffff;
   localparam logic [15:0] CRC_POLY   = 16'h8408;
   localparam logic [7:0]  VBASE_RST  = 8'h00;
   // vector codes, highest pending condition
   localparam logic [2:0] VEC_NONE    = 3'b111;
   localparam logic [2:0] VEC_B_EXT   = 3'b001;
   localparam logic [2:0] VEC_B_SPEC  = 3'b011;
   localparam logic [2:0] VEC_A_EXT   = 3'b101;
   localparam logic [2:0] VEC_A_SPEC  = 3'b111;

   typedef enum logic [2:0] {TX_OFF, TX_IDLE, TX_DATA, TX_CRC, TX_CLOSE, TX_ABORT} sfds_tx_t;
endpackage : sfds_pkg

// [sfds_dma_model.sv]
// behavioural dma controller that feeds transmit bytes on request
`timescale 1ns/1ps
module sfds_dma_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       req,
   input  wire logic [3:0] lag,
   input  wire logic [7:0] budget,
   output logic            hold_n,
   output logic            wr_n,
   output logic      [7:0] data,
   output logic      [7:0] served
);
   logic [3:0] wait_q;
   // lag plus two cycles of cool-down let the registered request fall before it is looked at again
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_n <= 1'b1;
         wr_n   <= 1'b1;
         data   <= 8'h00;
         served <= 8'h00;
         wait_q <= 4'h0;
      end else if (!wr_n) begin
         hold_n <= 1'b1;
         wr_n   <= 1'b1;
         data   <= ~data;
         served <= served + 8'd1;
         wait_q <= lag + 4'd2;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'd1;
      end else if (req && served != budget) begin
         hold_n <= 1'b0;
         wr_n   <= 1'b0;
         data   <= 8'h30 + served;
      end
   end
endmodule : sfds_dma_model

// [sdlc_frame_dma_service_bench.sv]
// self-checking bench for the frame dma service block
`timescale 1ns/1ps
module sdlc_frame_dma_service_bench;
   typedef struct packed {logic ev; logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;}
      sfds_row_t;
   logic        clk, nrst, hsel, hwrite, hreadyout, hresp, int_n, hold_n, wr_n, rq_a, rq_b;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans, cts_n, tick, txd, eof, tk, ovr;
   logic [7:0]  wdata, served, budget;
   int          miscompares = 0, total_checks = 0, i, n, m;
   sfds_row_t   rows[12];
   sfds_top uut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cts_n, .tx_bit_tick(tick), .txd,
      .rx_overrun_pulse(ovr), .rx_eof_pulse(eof), .rx_crc_err(2'h0), .rx_residue(6'h00),
      .hold_acknowledge_in_n(hold_n), .dma_rd_n(1'b1), .dma_wr_n(wr_n), .dma_wdata(wdata),
      .tx_dma_request_first_chan(rq_a), .tx_dma_request_second_chan(rq_b), .int_n);
   sfds_dma_model dmac (.clk, .nrst, .req(rq_a), .lag(4'h3), .budget, .hold_n, .wr_n,
      .data(wdata), .served);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // bit strobes restart with reset so only this process drives them
   always @(posedge clk) begin
      if (!nrst) begin
         tk <= 2'd0;
         tick <= 2'b00;
      end else begin
         tk <= tk + 2'd1;
         tick <= {2{tk == 2'd3}};
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one single word transfer; waits on hready in both phases
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk("hresp", hresp, 1'b0);
   endtask : ahb
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, eof, ovr, budget} = '0;
      nrst = 1'b0;
      cts_n = 2'b11;
      rows = '{'{0, 0, 8'h00, 0, 0}, '{0, 0, 8'h20, 0, 0}, '{0, 1, 8'h20, 32'ha0, 0},
               '{0, 0, 8'h20, 0, 32'ha0}, '{0, 0, 8'h30, 0, 0}, '{0, 1, 8'h10, 32'h0c, 0},
               '{0, 0, 8'h24, 0, 32'hbc}, '{1, 0, 8'h24, 0, 32'hac}, '{0, 1, 8'h10, 32'h4c, 0},
               '{0, 0, 8'h24, 0, 32'ha3}, '{0, 1, 8'h14, 32'h04, 0}, '{0, 0, 8'h24, 0, 32'ha7}};
      repeat (5) @(posedge clk);
      chk("reset", {txd, int_n, rq_a, rq_b, hreadyout, hresp}, 7'b1110010);
      nrst <= 1'b1;
      for (i = 0; i < 12; i++) begin
         if (rows[i].ev) begin
            eof <= 2'b10;
            @(posedge clk);
            eof <= 2'b00;
         end
         ahb(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk("row", r, rows[i].e);
      end
      ovr <= 2'b01;
      @(posedge clk);
      ovr <= 2'b00;
      ahb(0, 8'h0c, 0, r);
      chk("overrun", r[4], 1'b1);
      ahb(1, 8'h04, 32'h4, r);
      ahb(0, 8'h0c, 0, r);
      chk("err_reset", r[4], 1'b0);
      cts_n <= 2'b01;
      repeat (3) @(posedge clk);
      ahb(0, 8'h1c, 0, r);
      chk("cts", r[3:2], 2'b11);
      ahb(1, 8'h00, 32'h23, r);
      ahb(1, 8'h08, 32'h5a, r);
      budget <= 8'd3;
      for (i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge clk);
      chk("served", served, 8'd3);
      chk("int_n", int_n, 1'b0);
      ahb(0, 8'h0c, 0, r);
      chk("eom", r[1], 1'b1);
      chk("req", {rq_a, rq_b}, 2'b10);
      ahb(1, 8'h04, 32'h3, r);
      repeat (2) @(posedge clk);
      chk("req_a", rq_a, 1'b0);
      ahb(1, 8'h08, 32'h81, r);
      ahb(0, 8'h0c, 0, r);
      chk("inhibit", r[11], 1'b0);
      ahb(1, 8'h04, 32'h1, r);
      n = 0;
      m = 0;
      // longest run of ones on the line; flags and stuffed data never exceed six
      repeat (120) begin
         @(posedge clk);
         if (tick[0]) n = txd[0] ? n + 1 : 0;
         if (n > m) m = n;
      end
      chk("abort", (m >= 8 && m <= 13), 1'b1);
      test_done();
   end
endmodule : sdlc_frame_dma_service_bench
